/* File: design/cpm_pkg.sv */
/*
  shared constants for the clock output pin mux and strap status block:
  register indices, field positions, reset values, encodings and states.
  assumes every design and bench file refers to it as cpm_pkg::name.
*/
package cpm_pkg;

  // register indices; the byte address on the bus is four times the index
  localparam logic [15:0] IDX_CLOCK_OUTPUT_PIN_CONTROL = 16'h0463;
  localparam logic [15:0] IDX_STRAP_MODE_STATUS = 16'h0467;
  localparam logic [15:0] IDX_STRAP_CHECK_STATUS = 16'h04F0;
  localparam int unsigned BYTE_SHIFT = 2;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 16;
  localparam int unsigned BE_W = 4;

  // clock output pin control fields
  localparam int unsigned CLK_SEL_LSB = 4;
  localparam int unsigned CLK_SEL_W = 4;
  localparam int unsigned FUNC_LSB = 0;
  localparam int unsigned FUNC_W = 3;
  localparam logic [3:0] CLK_SEL_RESET = 4'h0;
  localparam logic [3:0] CLK_SEL_CRYSTAL = 4'h0;
  localparam logic [3:0] CLK_SEL_TRANSMIT = 4'h1;
  localparam logic [2:0] FUNC_RESET = 3'h1;

  // pin function encodings
  localparam logic [2:0] FUNC_STATUS_LIGHT_2 = 3'h0;
  localparam logic [2:0] FUNC_CLOCK = 3'h1;
  localparam logic [2:0] FUNC_WAKE_ON_LAN = 3'h2;
  localparam logic [2:0] FUNC_UNDERVOLTAGE = 3'h3;
  localparam logic [2:0] FUNC_TIMING_TX = 3'h4;
  localparam logic [2:0] FUNC_TIMING_RX = 3'h5;
  localparam logic [2:0] FUNC_CONST_LOW = 3'h6;
  localparam logic [2:0] FUNC_CONST_HIGH = 3'h7;

  // strap fields, two bits each, one per configuration pin
  localparam int unsigned STRAP_PINS = 8;
  localparam int unsigned MODE_W = 2;
  localparam int unsigned STRAP_AUTO_LSB = 14;
  localparam int unsigned STRAP_ADDR02_LSB = 12;
  localparam int unsigned STRAP_ADDR13_LSB = 10;
  localparam int unsigned STRAP_ROLE_LSB = 8;
  localparam int unsigned STRAP_IF0_LSB = 6;
  localparam int unsigned STRAP_IF1_LSB = 4;
  localparam int unsigned STRAP_IF2_LSB = 2;
  localparam int unsigned STRAP_RXD3_LSB = 0;
  localparam logic [1:0] MODE_1 = 2'h0;
  localparam logic [1:0] MODE_4 = 2'h3;

  // strap check status bits
  localparam int unsigned CHK_RXD3_BAD = 0;
  localparam int unsigned CHK_AUTO_RSVD = 1;
  localparam int unsigned CHK_ROLE_RSVD = 2;
  localparam int unsigned CHK_CAPTURED = 3;

  // cycles waited after reset release before the straps are latched; reset clears
  // the synchroniser, so the agreement filter shows the pins only after the fourth edge
  localparam int unsigned SETTLE_CYCLES = 5;
  localparam int unsigned SETTLE_W = 3;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ANSWER = 2'b10
  } cpm_bus_state_e;

  typedef enum logic [1:0] {
    CAP_SETTLE = 2'b01,
    CAP_HELD = 2'b10
  } cpm_cap_state_e;

endpackage : cpm_pkg

/* File: design/cpm_pin_sync.sv */
/*
  three stage synchroniser for a group of pin levels; the output only moves
  once the second and third stages agree.
  assumes the inputs are quasi static pin levels from outside the clock domain.
*/
`timescale 1ns/1ps
module cpm_pin_sync #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_stable
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // stage1 feeds stage2 only, so metastability never reaches a compare
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end
    else
    begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // per bit agreement filter
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_stable <= '0;
    end
    else
    begin
      pin_stable <= (stage2 & stage3) | (pin_stable & (stage2 ^ stage3));
    end
  end

endmodule : cpm_pin_sync

/* File: design/cpm_clock_pin_mux.sv */
/*
  clock output pin control register and strap mode status register behind an
  avalon-mm slave with waitrequest, plus strap capture and decode.
  assumes strap level detectors deliver a 2-bit mode number per pin, steady
  around reset release, and that pin event inputs come from sys_clk logic.
*/
// Contract
// - clock select bits 7:4 pick the pin's reference, 0000 crystal (reset) and 0001 transmit clock.
// - function bits 2:0 reset to 001 and map 000..111 to light 2, clock, wake, undervoltage, tx, rx, low, high.
// - strap status is read only and holds eight 2-bit mode numbers, 00 mode 1 up to 11 mode 4.
// - bits 15:14 give autonomous operation, 00 enabled, 11 disabled, others reserved.
// - bits 13:12 give address bits 0 and 2 as 00, 01, 11, 10 for modes 1 to 4.
// - bits 11:10 give address bits 1 and 3 as 00, 01, 11, 10 for modes 1 to 4.
// - bits 9:8 give the link role, 00 slave, 11 master, others reserved.
// - bits 7:6 give interface select bit 0 and test bit 0 as 00, 01, 11, 10 for modes 1 to 4.
// - bits 5:4 give interface select bit 1 and test bit 1 in the same way.
// - bits 3:2 give interface select bit 2 and test bit 2 in the same way.
// - bits 1:0 report the data line 3 strap, which must be mode 1; other modes are reserved.
`timescale 1ns/1ps
module cpm_clock_pin_mux #(
  parameter int unsigned ADDR_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  // avalon-mm slave, byte addressed
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [cpm_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [cpm_pkg::BE_W-1:0] avs_byteenable,
  output logic [cpm_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // strap mode numbers from the pin level detectors
  input wire logic [cpm_pkg::REG_W-1:0] strap_mode_pins,
  // sources for the clock output pin in its non-clock functions
  input wire logic status_light_2,
  input wire logic wake_on_lan_indication,
  input wire logic undervoltage_indication,
  input wire logic timing_tx_event,
  input wire logic timing_rx_event,
  // clock output pin steering
  output logic [cpm_pkg::CLK_SEL_W-1:0] clock_source_select,
  output logic transmit_reference_clock_selected,
  output logic clock_output_pin_clock_mode,
  output logic clock_output_pin_level,
  // decoded strap configuration
  output logic [3:0] phy_address_bits,
  output logic link_master,
  output logic autonomous_enable,
  output logic [2:0] interface_select_bits,
  output logic [2:0] test_mode_bits,
  output logic strap_captured,
  output logic strap_fault
);

  logic [cpm_pkg::REG_W-1:0] strap_stable;
  logic [cpm_pkg::REG_W-1:0] strap_mode_status;
  logic [cpm_pkg::CLK_SEL_W-1:0] clk_sel;
  logic [cpm_pkg::FUNC_W-1:0] func_sel;
  logic [cpm_pkg::SETTLE_W-1:0] settle_count;
  cpm_pkg::cpm_cap_state_e cap_state;
  cpm_pkg::cpm_bus_state_e bus_state;
  logic [ADDR_W-1:0] addr_ctrl;
  logic [ADDR_W-1:0] addr_strap;
  logic [ADDR_W-1:0] addr_check;
  logic hit_ctrl;
  logic hit_strap;
  logic hit_check;
  logic [cpm_pkg::REG_W-1:0] ctrl_view;
  logic [cpm_pkg::REG_W-1:0] check_view;
  logic [cpm_pkg::REG_W-1:0] next_read_word;
  logic [1:0] mode_auto;
  logic [1:0] mode_addr02;
  logic [1:0] mode_addr13;
  logic [1:0] mode_role;
  logic [1:0] mode_if0;
  logic [1:0] mode_if1;
  logic [1:0] mode_if2;
  logic [1:0] mode_rxd3;
  logic [1:0] pair_addr02;
  logic [1:0] pair_addr13;
  logic [1:0] pair_if0;
  logic [1:0] pair_if1;
  logic [1:0] pair_if2;
  logic next_pin_level;

  // mode number to the bit pair it stands for: 00, 01, 11, 10 for modes 1 to 4
  function automatic logic [1:0] mode_to_pair(input logic [1:0] mode);
    mode_to_pair = {mode[1], mode[1] ^ mode[0]};
  endfunction : mode_to_pair

  // strap pins cross into sys_clk before anything looks at them
  cpm_pin_sync #(
    .WIDTH(cpm_pkg::REG_W)
  ) u_strap_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in(strap_mode_pins),
    .pin_stable(strap_stable)
  );

  // capture sequencer: wait out the synchroniser, latch once, then hold
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cap_state <= cpm_pkg::CAP_SETTLE;
      settle_count <= '0;
    end
    else
    begin
      case (cap_state)
        cpm_pkg::CAP_SETTLE:
        begin
          if (settle_count == cpm_pkg::SETTLE_W'(cpm_pkg::SETTLE_CYCLES - 1))
          begin
            cap_state <= cpm_pkg::CAP_HELD;
          end
          else
          begin
            settle_count <= settle_count + 1'b1;
          end
        end
        cpm_pkg::CAP_HELD:
        begin
          cap_state <= cpm_pkg::CAP_HELD;
        end
        default:
        begin
          cap_state <= cpm_pkg::CAP_SETTLE;
        end
      endcase
    end
  end

  // strap register: written only at the settle exit, so later pin moves are ignored
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      strap_mode_status <= '0;
      strap_captured <= 1'b0;
    end
    else if (cap_state == cpm_pkg::CAP_SETTLE &&
             settle_count == cpm_pkg::SETTLE_W'(cpm_pkg::SETTLE_CYCLES - 1))
    begin
      strap_mode_status <= strap_stable;
      strap_captured <= 1'b1;
    end
  end

  // split the status word into its eight mode numbers
  assign mode_auto = strap_mode_status[cpm_pkg::STRAP_AUTO_LSB +: cpm_pkg::MODE_W];
  assign mode_addr02 = strap_mode_status[cpm_pkg::STRAP_ADDR02_LSB +: cpm_pkg::MODE_W];
  assign mode_addr13 = strap_mode_status[cpm_pkg::STRAP_ADDR13_LSB +: cpm_pkg::MODE_W];
  assign mode_role = strap_mode_status[cpm_pkg::STRAP_ROLE_LSB +: cpm_pkg::MODE_W];
  assign mode_if0 = strap_mode_status[cpm_pkg::STRAP_IF0_LSB +: cpm_pkg::MODE_W];
  assign mode_if1 = strap_mode_status[cpm_pkg::STRAP_IF1_LSB +: cpm_pkg::MODE_W];
  assign mode_if2 = strap_mode_status[cpm_pkg::STRAP_IF2_LSB +: cpm_pkg::MODE_W];
  assign mode_rxd3 = strap_mode_status[cpm_pkg::STRAP_RXD3_LSB +: cpm_pkg::MODE_W];

  // mode numbers are not pin levels; translate to the configured bit pairs
  assign pair_addr02 = mode_to_pair(mode_addr02);
  assign pair_addr13 = mode_to_pair(mode_addr13);
  assign pair_if0 = mode_to_pair(mode_if0);
  assign pair_if1 = mode_to_pair(mode_if1);
  assign pair_if2 = mode_to_pair(mode_if2);

  // decoded configuration outputs, registered; reserved role and autonomy codes fall back to defaults
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      phy_address_bits <= '0;
      link_master <= 1'b0;
      autonomous_enable <= 1'b0;
      interface_select_bits <= '0;
      test_mode_bits <= '0;
    end
    else
    begin
      phy_address_bits <= {pair_addr13[0], pair_addr02[0], pair_addr13[1], pair_addr02[1]};
      link_master <= (mode_role == cpm_pkg::MODE_4);
      autonomous_enable <= strap_captured && (mode_auto == cpm_pkg::MODE_1);
      interface_select_bits <= {pair_if2[1], pair_if1[1], pair_if0[1]};
      test_mode_bits <= {pair_if2[0], pair_if1[0], pair_if0[0]};
    end
  end

  // strap sanity: data line 3 off mode 1, or a reserved autonomy or role code
  assign check_view = {{(cpm_pkg::REG_W - cpm_pkg::CHK_CAPTURED - 1){1'b0}},
                       strap_captured,
                       (mode_role != cpm_pkg::MODE_1) && (mode_role != cpm_pkg::MODE_4),
                       (mode_auto != cpm_pkg::MODE_1) && (mode_auto != cpm_pkg::MODE_4),
                       strap_captured && (mode_rxd3 != cpm_pkg::MODE_1)};

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      strap_fault <= 1'b0;
    end
    else
    begin
      strap_fault <= strap_captured && (check_view[cpm_pkg::CHK_RXD3_BAD] ||
                     check_view[cpm_pkg::CHK_AUTO_RSVD] || check_view[cpm_pkg::CHK_ROLE_RSVD]);
    end
  end

  // address decode against byte addresses
  assign addr_ctrl = ADDR_W'({cpm_pkg::IDX_CLOCK_OUTPUT_PIN_CONTROL, 2'b00});
  assign addr_strap = ADDR_W'({cpm_pkg::IDX_STRAP_MODE_STATUS, 2'b00});
  assign addr_check = ADDR_W'({cpm_pkg::IDX_STRAP_CHECK_STATUS, 2'b00});

  always_comb
  begin
    hit_ctrl = 1'b0;
    hit_strap = 1'b0;
    hit_check = 1'b0;
    if (avs_address == addr_ctrl)
    begin
      hit_ctrl = 1'b1;
    end
    else if (avs_address == addr_strap)
    begin
      hit_strap = 1'b1;
    end
    else if (avs_address == addr_check)
    begin
      hit_check = 1'b1;
    end
  end

  // control register view; reserved positions are constant zero
  always_comb
  begin
    ctrl_view = '0;
    ctrl_view[cpm_pkg::CLK_SEL_LSB +: cpm_pkg::CLK_SEL_W] = clk_sel;
    ctrl_view[cpm_pkg::FUNC_LSB +: cpm_pkg::FUNC_W] = func_sel;
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    next_read_word = '0;
    if (hit_ctrl)
    begin
      next_read_word = ctrl_view;
    end
    else if (hit_strap)
    begin
      next_read_word = strap_mode_status;
    end
    else if (hit_check)
    begin
      next_read_word = check_view;
    end
  end

  // bus handshake: one wait cycle per access; held off until straps are latched
  // so software never reads a half settled strap word
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      bus_state <= cpm_pkg::BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end
    else
    begin
      case (bus_state)
        cpm_pkg::BUS_IDLE:
        begin
          avs_waitrequest <= 1'b1;
          if ((avs_read || avs_write) && strap_captured)
          begin
            bus_state <= cpm_pkg::BUS_ANSWER;
            avs_waitrequest <= 1'b0;
            avs_readdata <= {{(cpm_pkg::DATA_W - cpm_pkg::REG_W){1'b0}}, next_read_word};
          end
        end
        cpm_pkg::BUS_ANSWER:
        begin
          bus_state <= cpm_pkg::BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default:
        begin
          bus_state <= cpm_pkg::BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // control register write at the edge where the master sees waitrequest low;
  // only byte lane 0 carries live bits, status registers ignore writes
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      clk_sel <= cpm_pkg::CLK_SEL_RESET;
      func_sel <= cpm_pkg::FUNC_RESET;
    end
    else if (bus_state == cpm_pkg::BUS_ANSWER && avs_write && hit_ctrl && avs_byteenable[0])
    begin
      clk_sel <= avs_writedata[cpm_pkg::CLK_SEL_LSB +: cpm_pkg::CLK_SEL_W];
      func_sel <= avs_writedata[cpm_pkg::FUNC_LSB +: cpm_pkg::FUNC_W];
    end
  end

  // function mux for the pin's non-clock uses
  always_comb
  begin
    next_pin_level = 1'b0;
    case (func_sel)
      cpm_pkg::FUNC_STATUS_LIGHT_2: next_pin_level = status_light_2;
      cpm_pkg::FUNC_CLOCK: next_pin_level = 1'b0;
      cpm_pkg::FUNC_WAKE_ON_LAN: next_pin_level = wake_on_lan_indication;
      cpm_pkg::FUNC_UNDERVOLTAGE: next_pin_level = undervoltage_indication;
      cpm_pkg::FUNC_TIMING_TX: next_pin_level = timing_tx_event;
      cpm_pkg::FUNC_TIMING_RX: next_pin_level = timing_rx_event;
      cpm_pkg::FUNC_CONST_LOW: next_pin_level = 1'b0;
      cpm_pkg::FUNC_CONST_HIGH: next_pin_level = 1'b1;
      default: next_pin_level = 1'b0;
    endcase
  end

  // pin steering outputs; the clock itself is muxed in the pad ring, this only steers it
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      clock_source_select <= cpm_pkg::CLK_SEL_RESET;
      transmit_reference_clock_selected <= 1'b0;
      clock_output_pin_clock_mode <= 1'b1;
      clock_output_pin_level <= 1'b0;
    end
    else
    begin
      clock_source_select <= clk_sel;
      transmit_reference_clock_selected <= (clk_sel == cpm_pkg::CLK_SEL_TRANSMIT);
      clock_output_pin_clock_mode <= (func_sel == cpm_pkg::FUNC_CLOCK);
      clock_output_pin_level <= next_pin_level;
    end
  end

endmodule : cpm_clock_pin_mux

/* File: tb/cpm_clock_pin_mux_chk.sv */
/*
  concurrent checks on the clock output pin mux and strap status block.
  assumes it is bound to the top module and sees only that module's ports.
*/
`timescale 1ns/1ps
module cpm_clock_pin_mux_chk #(
  parameter int unsigned ADDR_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic [cpm_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [cpm_pkg::CLK_SEL_W-1:0] clock_source_select,
  input wire logic transmit_reference_clock_selected,
  input wire logic clock_output_pin_clock_mode,
  input wire logic clock_output_pin_level,
  input wire logic [3:0] phy_address_bits,
  input wire logic link_master,
  input wire logic autonomous_enable,
  input wire logic strap_captured,
  input wire logic strap_fault
);
  // one clock domain, so clock and reset are given once
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // reserved control bits must never leak into a read answer
  a_ctrl_rsvd_zero: assert property (!avs_waitrequest && avs_read && avs_address == 16'h118C
    |-> avs_readdata[15:8] == 8'h00 && !avs_readdata[3]) else $error("control reserved bits not zero");
  a_tx_clock_flag: assert property (transmit_reference_clock_selected == (clock_source_select == 4'h1))
    else $error("transmit clock flag disagrees with select");
  // settled clock mode drives no level of its own
  a_clock_mode_low: assert property (clock_output_pin_clock_mode && $past(clock_output_pin_clock_mode)
    |-> !clock_output_pin_level) else $error("pin level high in clock mode");
  a_captured_sticky: assert property (strap_captured |=> strap_captured)
    else $error("strap capture flag dropped");
  a_strap_outputs_hold: assert property ($past(strap_captured)
    |=> $stable({phy_address_bits, link_master, autonomous_enable, strap_fault})) else $error("strap outputs moved");
  a_auto_after_cap: assert property (autonomous_enable |-> strap_captured)
    else $error("autonomy before capture");
  a_master_after_cap: assert property (link_master |-> strap_captured)
    else $error("master role before capture");
  a_fault_after_cap: assert property (strap_fault |-> strap_captured)
    else $error("strap fault before capture");
  // no register answer is possible before the straps are latched
  a_no_early_answer: assert property (!strap_captured |-> avs_waitrequest)
    else $error("answer before strap capture");
  a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest ##1 avs_waitrequest)
    else $error("answer not a single cycle");
endmodule : cpm_clock_pin_mux_chk

bind cpm_clock_pin_mux cpm_clock_pin_mux_chk #(.ADDR_W(ADDR_W)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .clock_source_select(clock_source_select),
  .transmit_reference_clock_selected(transmit_reference_clock_selected),
  .clock_output_pin_clock_mode(clock_output_pin_clock_mode), .clock_output_pin_level(clock_output_pin_level),
  .phy_address_bits(phy_address_bits), .link_master(link_master), .autonomous_enable(autonomous_enable),
  .strap_captured(strap_captured), .strap_fault(strap_fault));

/* File: tb/cpm_clock_pin_mux_tb.sv */
/*
  self-checking bench for the clock output pin mux and strap status block.
  assumes the checker is bound in and the bench is the only bus master.
*/
`timescale 1ns/1ps
module cpm_clock_pin_mux_tb;
  localparam logic [15:0] A_CTRL = cpm_pkg::IDX_CLOCK_OUTPUT_PIN_CONTROL << cpm_pkg::BYTE_SHIFT;
  localparam logic [15:0] A_STRAP = cpm_pkg::IDX_STRAP_MODE_STATUS << cpm_pkg::BYTE_SHIFT;
  localparam logic [15:0] A_CHECK = cpm_pkg::IDX_STRAP_CHECK_STATUS << cpm_pkg::BYTE_SHIFT;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] avs_address = 16'h0000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] strap_mode_pins = 16'h0000;
  logic [4:0] src = 5'h00;
  logic [3:0] clock_source_select;
  logic tx_sel, clk_mode, pin_level, link_master, auto_en, strap_captured, strap_fault;
  logic [3:0] phy_address_bits;
  logic [2:0] if_bits, test_bits;
  wire logic [12:0] dec = {phy_address_bits, link_master, auto_en, if_bits, test_bits, strap_fault};
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;

  cpm_clock_pin_mux dut (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .strap_mode_pins(strap_mode_pins), .status_light_2(src[0]),
    .wake_on_lan_indication(src[1]), .undervoltage_indication(src[2]), .timing_tx_event(src[3]),
    .timing_rx_event(src[4]), .clock_source_select(clock_source_select),
    .transmit_reference_clock_selected(tx_sel), .clock_output_pin_clock_mode(clk_mode),
    .clock_output_pin_level(pin_level), .phy_address_bits(phy_address_bits), .link_master(link_master),
    .autonomous_enable(auto_en), .interface_select_bits(if_bits), .test_mode_bits(test_bits),
    .strap_captured(strap_captured), .strap_fault(strap_fault));

  // 25 MHz clock and a cycle ceiling so a stuck handshake cannot hang the run
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // one access; held until waitrequest is seen low, then one idle edge before returning;
  // only the bench's cycle ceiling ends a wait that never gets an answer
  task automatic bus_op(input logic wr, input logic [15:0] a, input logic [15:0] wd, output logic [31:0] rd);
    avs_address <= a;
    avs_writedata <= {16'h0000, wd};
    if (wr)
      avs_write <= 1'b1;
    else
      avs_read <= 1'b1;
    do
    begin
      @(posedge sys_clk);
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    chk(32'(avs_readdata[31:16]), 32'h0000_0000, "upper half of read data");
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : bus_op

  // pins are steady long before release, as the strap latch expects
  task automatic t_strap(input logic [15:0] pins, input logic [12:0] dec_exp, input logic [15:0] chk_exp);
    logic [31:0] d;
    int n;
    n = 0;
    strap_mode_pins <= pins;
    rst <= 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    while (strap_captured !== 1'b1 && n < 50)
    begin
      @(posedge sys_clk);
      n++;
    end
    repeat (2) @(posedge sys_clk);
    bus_op(1'b0, A_STRAP, 16'h0000, d);
    chk(d, {16'h0000, pins}, "strap status");
    chk(32'(dec), 32'(dec_exp), "strap decode");
    bus_op(1'b1, A_STRAP, ~pins, d);
    strap_mode_pins <= ~pins;
    repeat (10) @(posedge sys_clk);
    bus_op(1'b0, A_STRAP, 16'h0000, d);
    chk(d, {16'h0000, pins}, "strap after pin change");
    chk(32'(dec), 32'(dec_exp), "decode after pin change");
    bus_op(1'b0, A_CHECK, 16'h0000, d);
    chk(d, {16'h0000, chk_exp}, "strap check");
  endtask : t_strap

  task automatic t_ctrl();
    logic [31:0] d;
    bus_op(1'b0, A_CTRL, 16'h0000, d);
    chk(d, 32'h0000_0001, "control reset");
    chk(32'(clock_source_select), 32'h0000_0000, "crystal select at reset");
    bus_op(1'b1, A_CTRL, 16'hFFFF, d);
    bus_op(1'b0, A_CTRL, 16'h0000, d);
    chk(d, 32'h0000_00F7, "reserved bits");
    chk(32'({clock_source_select, tx_sel}), 32'h0000_001E, "select all ones");
    bus_op(1'b1, A_CTRL, 16'h0011, d);
    bus_op(1'b0, A_CTRL, 16'h0000, d);
    chk(d, 32'h0000_0011, "transmit clock");
    chk(32'({clock_source_select, tx_sel}), 32'h0000_0003, "transmit flag");
    // a write without byte lane 0 must leave the live fields alone
    avs_byteenable <= 4'hE;
    bus_op(1'b1, A_CTRL, 16'h0077, d);
    avs_byteenable <= 4'hF;
    bus_op(1'b0, A_CTRL, 16'h0000, d);
    chk(d, 32'h0000_0011, "write with lane 0 off");
    bus_op(1'b0, 16'h0100, 16'h0000, d);
    chk(d, 32'h0000_0000, "unmapped read");
  endtask : t_ctrl

  function automatic logic [4:0] fsrc(input logic [2:0] f);
    case (f)
      3'h0: fsrc = 5'h01;
      3'h2: fsrc = 5'h02;
      3'h3: fsrc = 5'h04;
      3'h4: fsrc = 5'h08;
      3'h5: fsrc = 5'h10;
      default: fsrc = 5'h00;
    endcase
  endfunction : fsrc

  // only the selected source is high, then all but it, so a swapped source shows
  task automatic t_func();
    logic [31:0] d;
    logic [2:0] f;
    for (int i = 0; i < 8; i++)
    begin
      f = 3'(i);
      bus_op(1'b1, A_CTRL, {13'h0000, f}, d);
      src <= fsrc(f);
      repeat (4) @(posedge sys_clk);
      chk(32'(pin_level), 32'(f == 3'h7 || fsrc(f) != 5'h00), "level source high");
      chk(32'(clk_mode), 32'(f == 3'h1), "clock mode");
      src <= ~fsrc(f);
      repeat (4) @(posedge sys_clk);
      chk(32'(pin_level), 32'(f == 3'h7), "level source low");
    end
  endtask : t_func

  initial
  begin
    t_strap(16'h27D8, 13'h1BDC, 16'h0008);
    t_ctrl();
    t_func();
    t_strap(16'hCC61, 13'h0427, 16'h0009);
    t_strap(16'h4200, 13'h0001, 16'h000E);
    report_and_stop();
  end
endmodule : cpm_clock_pin_mux_tb
